// File: rtl/secsup_cfg.svh
// register offsets, field positions, reset values and timing counts of the security supervisor
`ifndef SECSUP_CFG_SVH
`define SECSUP_CFG_SVH
// register byte offsets
`define OFF_EVT_STATUS 12'h000
`define OFF_IRQ_MASK 12'h004
`define OFF_REACTION 12'h008
`define OFF_SEC_CTRL 12'h00c
`define OFF_MEM_RIGHTS 12'h010
`define OFF_REGION_BASE 12'h020
`define OFF_REGION_ATTR 12'h030
`define OFF_MODE 12'h040
`define OFF_TRACE 12'h044
`define OFF_FAULT 12'h048
`define OFF_TEST_KEY 12'h04c
// field positions
`define EVT_COUNT 7
`define BIT_FIQ_EVT 7
`define BIT_WR_EN 0
`define BIT_LOCKED 1
`define BIT_USER 0
`define BIT_NORMAL 1
`define BIT_TEST_OPEN 2
`define ATTR_RD 0
`define ATTR_WR 1
`define ATTR_EX 2
`define ATTR_PROG 3
// reset values
`define RST_MASK 8'h00
`define RST_REACTION 7'h00
`define RST_RIGHTS 4'hf
`define RST_TRACE 32'h00000000
// timing: write-enable window after reset, in clock cycles
`define WREN_WINDOW_CYCLES 128
// filter length for pad inputs, in clock cycles
`define PAD_FILTER_CYCLES 4
`define TEST_KEY_DEFAULT 32'h5a5a0f0f
`endif

// File: rtl/secsup_pkg.sv
// types shared by the security supervisor files
`default_nettype none
package secsup_pkg;
  // lifecycle of the chip: test first, then normal until the next reset
  typedef enum logic [1:0] {
    LIFE_TEST = 2'b01,
    LIFE_NORMAL = 2'b10
  } life_t;
  // security register write window
  typedef enum logic [2:0] {
    WIN_OPEN = 3'b001,
    WIN_ENABLED = 3'b010,
    WIN_LOCKED = 3'b100
  } win_t;
endpackage
`default_nettype wire

// File: rtl/pad_filter.sv
// glitch filter for an external pad: three-flop sync then a stable-run counter
`default_nettype none
`include "secsup_cfg.svh"
module pad_filter (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pad_i,
  input wire logic rst_value_i,
  output logic filt_o
);
  logic s1_r; // first sync stage, read only by s2_r
  logic s2_r;
  logic s3_r;
  logic [2:0] run_r; // cycles the synced level has held
  logic [2:0] run_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pad_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // run counter restarts on any disagreement, so short pulses never pass
  always_comb begin
    run_nxt = run_r;
    if (s2_r != s3_r || s3_r == filt_o) begin
      run_nxt = 3'h0;
    end else if (run_r != 3'(`PAD_FILTER_CYCLES - 1)) begin
      run_nxt = run_r + 3'h1;
    end
  end

  // output flips only after the level held the full filter length
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_r <= 3'h0;
      filt_o <= 1'b0;
    end else begin
      run_r <= run_nxt;
      if (s2_r == s3_r && s3_r != filt_o && run_r == 3'(`PAD_FILTER_CYCLES - 1)) begin
        filt_o <= s3_r;
      end
    end
  end
  // rst_value_i is accepted for symmetry of pads; both pads idle low
  logic unused_rst_value;
  assign unused_rst_value = rst_value_i;
endmodule
`default_nettype wire

// File: rtl/security_supervisor.sv
// security supervisor: detector capture, reaction, pad filters, register lock, access checks
//
// The address map and the AXI4-Lite register port were decided locally.
`default_nettype none
`include "secsup_cfg.svh"
module security_supervisor (
  input wire logic clk_i,
  input wire logic reset_i,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // detectors: freq, volt, temp, light, insulation, shield, glitch
  input wire logic [6:0] detect_i,
  // external pads
  input wire logic ext_reset_pad_i,
  input wire logic ext_clock_pad_i,
  // cpu access monitor
  input wire logic acc_valid_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic acc_write_i,
  input wire logic acc_fetch_i,
  input wire logic acc_prog_i,
  input wire logic acc_eeprom_i,
  input wire logic acc_mapped_i,
  input wire logic privileged_i,
  output logic chip_reset_o,
  output logic fiq_o,
  output logic irq_o,
  output logic ext_reset_filt_o,
  output logic ext_clock_filt_o,
  output logic normal_mode_o
);
  localparam int NREG = 4; // protection regions

  logic [7:0] status_r; // sticky events, bit 7 = access fault
  logic [7:0] mask_r;
  logic [6:0] reaction_r; // 1 = reset chip on that detector
  logic [3:0] rights_r; // global rd/wr/ex/prog enables
  logic [31:0] base_r [NREG]; // region upper bound (exclusive), ascending
  logic [3:0] attr_r [NREG];
  secsup_pkg::win_t win_r;
  logic [7:0] win_cnt_r;
  secsup_pkg::life_t life_r;
  logic test_open_r;
  logic [31:0] trace_r;
  logic [31:0] fault_addr_r;
  logic [6:0] det_s1_r, det_s2_r, det_s3_r;
  logic [6:0] det_evt;
  logic viol;
  logic evt_reset;
  // bus side
  logic aw_got_r, w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wr_fire, rd_fire;
  logic [31:0] rd_val;
  logic rd_ok, wr_ok;
  logic sec_wr_allowed;

  ////////////////////////////////////////////////////////////////////////////
  // detector inputs pass three flops; an event is an agreed high level
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      det_s1_r <= 7'h00;
      det_s2_r <= 7'h00;
      det_s3_r <= 7'h00;
    end else begin
      det_s1_r <= detect_i;
      det_s2_r <= det_s1_r;
      det_s3_r <= det_s2_r;
    end
  end
  // detectors have no enable anywhere: software only sets reaction and irq mask bits
  assign det_evt = det_s2_r & det_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // pad filters, fixed in hardware
  pad_filter u_rst_filt (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pad_i(ext_reset_pad_i),
    .rst_value_i(1'b0),
    .filt_o(ext_reset_filt_o)
  );
  pad_filter u_clk_filt (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pad_i(ext_clock_pad_i),
    .rst_value_i(1'b0),
    .filt_o(ext_clock_filt_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // region rights check; first region whose bound exceeds the address wins
  function automatic logic access_ok(input logic [31:0] a, input logic wr, input logic ex,
                                     input logic prog, input logic [3:0] g,
                                     input logic [31:0] b0, input logic [31:0] b1,
                                     input logic [31:0] b2, input logic [31:0] b3,
                                     input logic [3:0] t0, input logic [3:0] t1,
                                     input logic [3:0] t2, input logic [3:0] t3);
    logic [3:0] at;
    logic ok;
    at = (a < b0) ? t0 : (a < b1) ? t1 : (a < b2) ? t2 : (a < b3) ? t3 : 4'h0;
    ok = (at[`ATTR_PROG] == prog);
    if (ex) begin
      ok = ok & at[`ATTR_EX] & g[`ATTR_EX];
    end else if (wr) begin
      ok = ok & at[`ATTR_WR] & g[`ATTR_WR];
    end else begin
      ok = ok & at[`ATTR_RD] & g[`ATTR_RD];
    end
    access_ok = ok & (g[`ATTR_PROG] | ~prog);
  endfunction

  always_comb begin
    viol = 1'b0;
    if (acc_valid_i) begin
      if (!acc_mapped_i) begin
        viol = 1'b1;
      end else if (acc_fetch_i && acc_eeprom_i && !rights_r[`ATTR_EX]) begin
        viol = 1'b1;
      end else if (!access_ok(acc_addr_i, acc_write_i, acc_fetch_i, acc_prog_i, rights_r,
                              base_r[0], base_r[1], base_r[2], base_r[3],
                              attr_r[0], attr_r[1], attr_r[2], attr_r[3])) begin
        viol = 1'b1;
      end
    end
  end

  // fiq is high one cycle after each violating access cycle and has no mask: it cannot be suppressed
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fiq_o <= 1'b0;
      fault_addr_r <= 32'h00000000;
    end else begin
      fiq_o <= viol;
      if (viol) begin
        fault_addr_r <= acc_addr_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reaction: reset-configured detectors pull chip reset for as long as their event lasts
  assign evt_reset = |(det_evt & reaction_r);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      chip_reset_o <= 1'b0;
    end else begin
      chip_reset_o <= evt_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi handshake: address and data accepted independently
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign sec_wr_allowed = (win_r == secsup_pkg::WIN_ENABLED) || privileged_i;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write decode: slverr on unmapped, locked or frozen targets
  always_comb begin
    wr_ok = 1'b1;
    case (awaddr_r)
      `OFF_IRQ_MASK, `OFF_EVT_STATUS, `OFF_SEC_CTRL, `OFF_FAULT: wr_ok = 1'b1;
      `OFF_REACTION, `OFF_MEM_RIGHTS: wr_ok = sec_wr_allowed;
      `OFF_MODE: wr_ok = 1'b1;
      `OFF_TRACE: wr_ok = (life_r == secsup_pkg::LIFE_TEST) && test_open_r;
      `OFF_TEST_KEY: wr_ok = (life_r == secsup_pkg::LIFE_TEST);
      default: begin
        wr_ok = (awaddr_r[11:4] == 8'h02 || awaddr_r[11:4] == 8'h03) && sec_wr_allowed;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // security register write window after reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      win_r <= secsup_pkg::WIN_OPEN;
      win_cnt_r <= 8'h00;
    end else begin
      case (win_r)
        secsup_pkg::WIN_OPEN: begin
          win_cnt_r <= win_cnt_r + 8'h01;
          if (wr_fire && awaddr_r == `OFF_SEC_CTRL && wdata_r[`BIT_WR_EN] && !privileged_i) begin
            win_r <= secsup_pkg::WIN_ENABLED;
          end else if (win_cnt_r == 8'(`WREN_WINDOW_CYCLES - 1)) begin
            win_r <= secsup_pkg::WIN_LOCKED;
          end
        end
        secsup_pkg::WIN_ENABLED: win_r <= secsup_pkg::WIN_ENABLED;
        secsup_pkg::WIN_LOCKED: win_r <= secsup_pkg::WIN_LOCKED;
        default: win_r <= secsup_pkg::WIN_LOCKED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers, all with reset defaults
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_r <= `RST_MASK;
      reaction_r <= `RST_REACTION;
      rights_r <= `RST_RIGHTS;
      for (int i = 0; i < NREG; i++) begin
        base_r[i] <= 32'hffffffff;
        attr_r[i] <= 4'h7;
      end
    end else if (wr_fire && wr_ok) begin
      case (awaddr_r)
        `OFF_IRQ_MASK: mask_r <= wdata_r[7:0];
        `OFF_REACTION: reaction_r <= wdata_r[6:0];
        `OFF_MEM_RIGHTS: rights_r <= wdata_r[3:0];
        default: begin
          if (awaddr_r[11:4] == 8'h02) begin
            base_r[awaddr_r[3:2]] <= wdata_r;
          end
          if (awaddr_r[11:4] == 8'h03) begin
            attr_r[awaddr_r[3:2]] <= wdata_r[3:0];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lifecycle: test needs password; normal is one way
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      life_r <= secsup_pkg::LIFE_TEST;
      test_open_r <= 1'b0;
      trace_r <= `RST_TRACE;
    end else begin
      case (life_r)
        secsup_pkg::LIFE_TEST: begin
          if (wr_fire && awaddr_r == `OFF_TEST_KEY && wdata_r == `TEST_KEY_DEFAULT) begin
            test_open_r <= 1'b1;
          end
          if (wr_fire && wr_ok && awaddr_r == `OFF_TRACE) begin
            trace_r <= wdata_r;
          end
          if (wr_fire && awaddr_r == `OFF_MODE && wdata_r[`BIT_NORMAL]) begin
            life_r <= secsup_pkg::LIFE_NORMAL;
            test_open_r <= 1'b0;
          end
        end
        secsup_pkg::LIFE_NORMAL: begin
          life_r <= secsup_pkg::LIFE_NORMAL;
          test_open_r <= 1'b0;
        end
        default: life_r <= secsup_pkg::LIFE_NORMAL;
      endcase
    end
  end
  // note: a real part keeps lifecycle in nonvolatile cells; here reset restarts it

  ////////////////////////////////////////////////////////////////////////////
  // sticky status: set wins over the read clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= 8'h00;
    end else begin
      status_r <= ((rd_fire && s_axi_araddr == `OFF_EVT_STATUS) ? 8'h00 : status_r)
                  | {viol, det_evt};
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      normal_mode_o <= 1'b0;
    end else begin
      irq_o <= |(status_r & mask_r);
      normal_mode_o <= (life_r == secsup_pkg::LIFE_NORMAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `OFF_EVT_STATUS: rd_val = {24'h000000, status_r};
      `OFF_IRQ_MASK: rd_val = {24'h000000, mask_r};
      `OFF_REACTION: rd_val = {25'h0, reaction_r};
      `OFF_SEC_CTRL: rd_val = {30'h0, win_r == secsup_pkg::WIN_LOCKED,
                               win_r == secsup_pkg::WIN_ENABLED};
      `OFF_MEM_RIGHTS: rd_val = {28'h0000000, rights_r};
      `OFF_MODE: rd_val = {29'h0, test_open_r,
                           life_r == secsup_pkg::LIFE_NORMAL, ~privileged_i};
      `OFF_TRACE: rd_val = trace_r;
      `OFF_FAULT: rd_val = fault_addr_r;
      `OFF_TEST_KEY: rd_val = 32'h00000000;
      default: begin
        if (s_axi_araddr[11:4] == 8'h02) begin
          rd_val = base_r[s_axi_araddr[3:2]];
        end else if (s_axi_araddr[11:4] == 8'h03) begin
          rd_val = {28'h0000000, attr_r[s_axi_araddr[3:2]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // read channel: one outstanding read, answer one cycle after ar taken
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  logic unused_strb;
  assign unused_strb = ^s_axi_wstrb;
endmodule
`default_nettype wire

// File: dv/security_supervisor_monitor.sv
// assertion checker bound to the security supervisor top-level ports
`default_nettype none
module security_supervisor_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [6:0] detect_i,
  input wire logic ext_reset_pad_i,
  input wire logic ext_clock_pad_i,
  input wire logic acc_valid_i,
  input wire logic acc_mapped_i,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic chip_reset_o,
  input wire logic fiq_o,
  input wire logic irq_o,
  input wire logic ext_reset_filt_o,
  input wire logic ext_clock_filt_o,
  input wire logic normal_mode_o
);
  // single clock domain, so one default clocking serves all checks
  default clocking cb @(posedge clk_i);
  endclocking
  //////////////////////////////////////////////////////////////////////
  // no reset disable here: this one is about the reset itself
  property p_reset_quiet;
    reset_i |-> !fiq_o && !irq_o && !chip_reset_o && !normal_mode_o && !s_axi_bvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active during reset");
  // a chip reset pulse needs a detector level a few cycles back
  property p_reset_cause;
    disable iff (reset_i)
    chip_reset_o |-> ($past(detect_i, 3) | $past(detect_i, 4) | $past(detect_i, 5)) != 7'h00;
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("chip reset without detector event");
  // filtered reset pad only moves after the pad held the new level
  property p_rst_pad_filter;
    disable iff (reset_i)
    $changed(ext_reset_filt_o) |-> $past(ext_reset_pad_i, 4) == ext_reset_filt_o &&
      $past(ext_reset_pad_i, 5) == ext_reset_filt_o;
  endproperty
  a_rst_pad_filter: assert property (p_rst_pad_filter)
    else $error("reset pad glitch passed the filter");
  // same for the clock pad; no register can bypass it
  property p_clk_pad_filter;
    disable iff (reset_i)
    $changed(ext_clock_filt_o) |-> $past(ext_clock_pad_i, 4) == ext_clock_filt_o &&
      $past(ext_clock_pad_i, 5) == ext_clock_filt_o;
  endproperty
  a_clk_pad_filter: assert property (p_clk_pad_filter)
    else $error("clock pad glitch passed the filter");
  // an access outside the map always traps on the next cycle
  property p_unmapped_fiq;
    disable iff (reset_i)
    acc_valid_i && !acc_mapped_i |=> fiq_o;
  endproperty
  a_unmapped_fiq: assert property (p_unmapped_fiq)
    else $error("unmapped access gave no fast interrupt");
  // the fast interrupt only follows an access
  property p_fiq_cause;
    disable iff (reset_i)
    fiq_o |-> $past(acc_valid_i);
  endproperty
  a_fiq_cause: assert property (p_fiq_cause)
    else $error("fast interrupt without access");
  // normal mode never falls back before a reset
  property p_normal_sticky;
    disable iff (reset_i)
    normal_mode_o |=> normal_mode_o;
  endproperty
  a_normal_sticky: assert property (p_normal_sticky)
    else $error("normal mode left without reset");
  // bus stays closed while a write response is pending
  property p_write_closed;
    disable iff (reset_i)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_closed: assert property (p_write_closed)
    else $error("write channel ready during response");
endmodule
bind security_supervisor security_supervisor_monitor i_monitor (
  .clk_i, .reset_i, .detect_i, .ext_reset_pad_i, .ext_clock_pad_i, .acc_valid_i,
  .acc_mapped_i, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .chip_reset_o, .fiq_o,
  .irq_o, .ext_reset_filt_o, .ext_clock_filt_o, .normal_mode_o
);
`default_nettype wire

// File: dv/security_supervisor_bench.sv
// self-checking bench for the security supervisor
`default_nettype none
`include "secsup_cfg.svh"
module security_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, privileged_i;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, acc_addr_i;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] detect_i;
  logic ext_reset_pad_i, ext_clock_pad_i, acc_valid_i, acc_write_i, acc_fetch_i;
  logic acc_prog_i, acc_eeprom_i, acc_mapped_i;
  logic chip_reset_o, fiq_o, irq_o, ext_reset_filt_o, ext_clock_filt_o, normal_mode_o;
  int error_cnt, n_compared;
  // registers with a fixed reset value (trace is left out: refused outside test)
  logic [11:0] regs [13] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h020, 12'h024,
    12'h028, 12'h02c, 12'h030, 12'h034, 12'h038, 12'h03c, 12'h048};
  security_supervisor i_dut (
    .clk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .detect_i, .ext_reset_pad_i, .ext_clock_pad_i,
    .acc_valid_i, .acc_addr_i, .acc_write_i, .acc_fetch_i, .acc_prog_i, .acc_eeprom_i,
    .acc_mapped_i, .privileged_i, .chip_reset_o, .fiq_o, .irq_o, .ext_reset_filt_o,
    .ext_clock_filt_o, .normal_mode_o
  );
  // 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////
  // one compare for all results; narrow values widen to a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a wait that runs out is a mismatch and ends the run
  task automatic tmo();
    chk(32'h0, 32'h1);
    finish_test();
  endtask
  function automatic logic [31:0] rst_val(input logic [11:0] a);
    if (a == `OFF_MEM_RIGHTS) return {28'h0, `RST_RIGHTS};
    if (a >= `OFF_REGION_BASE && a < `OFF_REGION_ATTR) return 32'hffffffff;
    if (a >= `OFF_REGION_ATTR && a < `OFF_MODE) return 32'h00000007;
    return 32'h00000000;
  endfunction
  function automatic logic [31:0] evt_bit(input int i);
    return 32'h1 << i;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // handshakes are judged at the falling edge, where outputs have settled
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    bh = 1'b0;
    for (n = 0; n < 50 && !bh; n++) begin
      @(negedge clk_i);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
    end
    if (!bh) tmo();
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    int n;
    @(posedge clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    rh = 1'b0;
    for (n = 0; n < 50 && !rh; n++) begin
      @(negedge clk_i);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
    end
    if (!rh) tmo();
  endtask
  // two-cycle detector level, then count chip reset high cycles over ten cycles
  task automatic pulse(input int i, output int n);
    @(posedge clk_i);
    detect_i <= 7'h01 << i;
    cyc(2);
    detect_i <= 7'h00;
    n = 0;
    repeat (10) begin
      @(negedge clk_i);
      if (chip_reset_o === 1'b1) n++;
    end
  endtask
  // kind bits: write, fetch, prog, eeprom, mapped
  task automatic acc(input logic [4:0] k, input logic e);
    @(posedge clk_i);
    {acc_write_i, acc_fetch_i, acc_prog_i, acc_eeprom_i, acc_mapped_i} <= k;
    acc_valid_i <= 1'b1;
    acc_addr_i <= $urandom;
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    @(negedge clk_i);
    chk(fiq_o, e);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int k, n;
    k = $urandom(47);
    // raise reset after time zero so the asynchronous reset surely sees an edge
    #1 reset_i = 1'b1;
    {privileged_i, acc_valid_i, acc_write_i, acc_fetch_i, acc_prog_i} = 5'h00;
    {acc_eeprom_i, acc_mapped_i, ext_reset_pad_i, ext_clock_pad_i} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, acc_addr_i} = '0;
    detect_i = 7'h00;
    s_axi_wstrb = 4'hf;
    cyc(6);
    reset_i <= 1'b0;
    // user mode opens the lock first: the window is short
    axw(`OFF_SEC_CTRL, 32'h1, r);
    axr(`OFF_SEC_CTRL, d, r);
    chk(d[1:0], 2'b01);
    foreach (regs[j]) begin
      axr(regs[j], d, r);
      chk(d, rst_val(regs[j]));
    end
    axr(12'h0fc, d, r);
    chk(r, 2'b10);
    // reset reaction on one random detector only
    k = $urandom_range(6, 0);
    axw(`OFF_REACTION, evt_bit(k), r);
    chk(r, 2'b00);
    pulse(k, n);
    chk(n, 1);
    pulse((k + 1) % 7, n);
    chk(n, 0);
    axw(`OFF_REACTION, 32'h0, r);
    axr(`OFF_EVT_STATUS, d, r);
    chk(d, evt_bit(k) | evt_bit((k + 1) % 7));
    // every detector with a random mask; a status read clears it
    for (int i = 0; i < 7; i++) begin
      k = $urandom;
      axw(`OFF_IRQ_MASK, {24'h0, k[7:0]}, r);
      pulse(i, n);
      chk(irq_o, k[i]);
      axr(`OFF_EVT_STATUS, d, r);
      chk(d, evt_bit(i));
      cyc(2);
      @(negedge clk_i);
      chk(irq_o, 1'b0);
    end
    acc(5'b00001, 1'b0);
    acc(5'b00000, 1'b1);
    axw(`OFF_MEM_RIGHTS, 32'hd, r);
    acc(5'b10001, 1'b1);
    axw(`OFF_MEM_RIGHTS, 32'hf, r);
    acc(5'b01011, 1'b0);
    for (int j = 0; j < 4; j++) axw(12'(`OFF_REGION_ATTR + 4 * j), 32'h3, r);
    acc(5'b01011, 1'b1);
    axr(`OFF_EVT_STATUS, d, r);
    chk(d[7], 1'b1);
    // second reset, window missed: lock holds even against the enable bit
    @(posedge clk_i);
    reset_i <= 1'b1;
    cyc(6);
    reset_i <= 1'b0;
    cyc(`WREN_WINDOW_CYCLES + 8);
    axw(`OFF_REACTION, 32'h1, r);
    chk(r, 2'b10);
    axw(`OFF_SEC_CTRL, 32'h1, r);
    axr(`OFF_SEC_CTRL, d, r);
    chk(d[1:0], 2'b10);
    privileged_i <= 1'b1;
    axw(`OFF_REACTION, 32'h0, r);
    chk(r, 2'b00);
    // test entry needs the key; trace is writable only while open
    axw(`OFF_TEST_KEY, 32'h0, r);
    axw(`OFF_TRACE, 32'h1, r);
    chk(r, 2'b10);
    axw(`OFF_TEST_KEY, `TEST_KEY_DEFAULT, r);
    axr(`OFF_MODE, d, r);
    chk(d[2:1], 2'b10);
    k = $urandom;
    axw(`OFF_TRACE, k, r);
    axr(`OFF_TRACE, d, r);
    chk(d, k);
    axw(`OFF_MODE, 32'h2, r);
    axw(`OFF_TRACE, ~k, r);
    chk(r, 2'b10);
    axw(`OFF_TEST_KEY, `TEST_KEY_DEFAULT, r);
    chk(r, 2'b10);
    axw(`OFF_MODE, 32'h0, r);
    @(negedge clk_i);
    chk(normal_mode_o, 1'b1);
    // a two-cycle pad glitch is dropped, a steady level gets through
    @(posedge clk_i);
    {ext_reset_pad_i, ext_clock_pad_i} <= 2'b11;
    cyc(2);
    {ext_reset_pad_i, ext_clock_pad_i} <= 2'b00;
    cyc(12);
    @(negedge clk_i);
    chk({ext_reset_filt_o, ext_clock_filt_o}, 2'b00);
    @(posedge clk_i);
    {ext_reset_pad_i, ext_clock_pad_i} <= 2'b11;
    cyc(12);
    @(negedge clk_i);
    chk({ext_reset_filt_o, ext_clock_filt_o}, 2'b11);
    finish_test();
  end
endmodule
`default_nettype wire
